// *** shared/bgx_defines.svh ***
// Contract
// - expander 4 high direction bit 0 sets pin 8: 0 input, 1 output.
// - expander 4 high direction bit 1 sets pin 9: 0 input, 1 output.
// - bit 7 sets pin 15 direction; bits 2 to 6 reserved, still writable.
// - expander 5 low input byte is read-only; writes change nothing.
// - low input bits 0-2 mirror clock mux pins, 3-7 lane switch selects.
// - each mirror bit reads 0 for a low pin and 1 for a high pin.
// - high input byte at 19h mirrors switch3 hi, config done, io enable.
// - config done bit ignores writes and always mirrors the live pin.
// - expander 5 low output byte at 1Ah is read/write, resets to 00.
// - output bits 0-2 drive clock mux pins, 3-7 lane switch selects.
// - output bit 0 drives its pin low, 1 drives it high.
`ifndef BGX_DEFINES_SVH
`define BGX_DEFINES_SVH

// register indices; byte address is four times the index
`define BGX_IDX_DIR4_HI   6'h17
`define BGX_IDX_IN5_LO    6'h18
`define BGX_IDX_IN5_HI    6'h19
`define BGX_IDX_OUT5_LO   6'h1a
`define BGX_IDX_DIR5_LO   6'h1c

`define BGX_RST_DIR4_HI   8'h00
`define BGX_RST_OUT5_LO   8'h00
`define BGX_RST_DIR5_LO   8'h00

// field positions
`define BGX_DIR4_PIN8     0
`define BGX_DIR4_PIN9     1
`define BGX_DIR4_PIN15    7
`define BGX_IN5HI_SW3HI   0
`define BGX_IN5HI_DONE    1
`define BGX_IN5HI_IOEN    2

`define BGX_RESP_OKAY     2'h0
`define BGX_RESP_SLVERR   2'h2

`endif

// *** shared/bgx_pkg.sv ***
package bgx_pkg;

  typedef struct packed {
    logic       awready;
    logic       wready;
    logic       aw_held;
    logic [7:0] aw_addr;
    logic       w_held;
    logic [7:0] w_data;
    logic       w_strb0;
    logic       bvalid;
    logic [1:0] bresp;
    logic       arready;
    logic       rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [7:0] dir4_hi;
    logic [7:0] out5_lo;
    logic [7:0] dir5_lo;
  } bgx_state_t;

  typedef struct packed {
    logic pin;
    logic oe;
  } bgx_cell_t;

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
  } bgx_sync_pair_t;

endpackage : bgx_pkg

// *** logic/bgx_sync.sv ***
`timescale 1ns/10ps
// two-stage synchroniser for asynchronous pin levels
module bgx_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             mclk_i,
  input  wire logic             nrst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } bgx_sync_st_t;

  bgx_sync_st_t st;
  bgx_sync_st_t next_st;

  always_comb begin
    next_st.meta   = async_i;
    next_st.stable = st.meta;
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_o = st.stable;

endmodule : bgx_sync

// *** logic/bgx_pin_cell.sv ***
`timescale 1ns/10ps
// registered two-way pin driver: value and enable leave from flops
module bgx_pin_cell (
  input  wire logic mclk_i,
  input  wire logic nrst_i,
  input  wire logic value_i,
  input  wire logic dir_out_i,
  output logic      pin_o,
  output logic      pin_oe_o
);

  bgx_pkg::bgx_cell_t st;
  bgx_pkg::bgx_cell_t next_st;

  always_comb begin
    next_st.pin = value_i;
    next_st.oe  = dir_out_i;
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pin_o    = st.pin;
  assign pin_oe_o = st.oe;

endmodule : bgx_pin_cell

// *** logic/bgx_gpio_regs.sv ***
`timescale 1ns/10ps
`include "bgx_defines.svh"
// expander register slice behind an axi4-lite slave
module bgx_gpio_regs (
  input  wire logic       mclk_i,
  input  wire logic       nrst_i,
  // axi4-lite write address
  input  wire logic       s_axi_awvalid,
  output logic            s_axi_awready,
  input  wire logic [7:0] s_axi_awaddr,
  input  wire logic [2:0] s_axi_awprot,
  // axi4-lite write data
  input  wire logic       s_axi_wvalid,
  output logic            s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic            s_axi_bvalid,
  input  wire logic       s_axi_bready,
  output logic [1:0]      s_axi_bresp,
  // axi4-lite read address
  input  wire logic       s_axi_arvalid,
  output logic            s_axi_arready,
  input  wire logic [7:0] s_axi_araddr,
  input  wire logic [2:0] s_axi_arprot,
  // axi4-lite read data
  output logic            s_axi_rvalid,
  input  wire logic       s_axi_rready,
  output logic [31:0]     s_axi_rdata,
  output logic [1:0]      s_axi_rresp,
  // expander 4 pins 8, 9, 15 direction levels
  output logic            x4_pin8_dir_o,
  output logic            x4_pin9_dir_o,
  output logic            x4_pin15_dir_o,
  // expander 5 pins 0..7: clock_mux_select[2:0], lane switch selects
  input  wire logic [7:0] x5_pin_i,
  output logic      [7:0] x5_pin_o,
  output logic      [7:0] x5_pin_oe_o,
  // expander 5 read-only mirrors
  input  wire logic       lane_switch3_sel_hi_i,
  input  wire logic       config_done_pin_i,
  input  wire logic       expander_io_enable_pin_i
);

  bgx_pkg::bgx_state_t st;
  bgx_pkg::bgx_state_t next_st;

  logic [7:0] x5_sync;
  logic [2:0] hi_sync;
  logic [7:0] wr_byte;
  logic [7:0] rd_byte;
  logic       rd_hit;
  logic       wr_hit;
  logic       aw_take;
  logic       w_take;
  logic       ar_take;
  logic       do_write;

  // ---------------------------------------------------------------
  // pin level capture
  // ---------------------------------------------------------------
  bgx_sync #(
    .WIDTH (8)
  ) u_sync_x5 (
    .mclk_i  (mclk_i),
    .nrst_i  (nrst_i),
    .async_i (x5_pin_i),
    .sync_o  (x5_sync)
  );

  bgx_sync #(
    .WIDTH (3)
  ) u_sync_hi (
    .mclk_i  (mclk_i),
    .nrst_i  (nrst_i),
    .async_i ({expander_io_enable_pin_i,
               config_done_pin_i,
               lane_switch3_sel_hi_i}),
    .sync_o  (hi_sync)
  );

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // true for any index that names a register of this slice
  function automatic logic bgx_mapped(input logic [7:0] addr);
    logic [5:0] idx;
    idx = addr[7:2];
    case (idx)
      `BGX_IDX_DIR4_HI: bgx_mapped = 1'b1;
      `BGX_IDX_IN5_LO:  bgx_mapped = 1'b1;
      `BGX_IDX_IN5_HI:  bgx_mapped = 1'b1;
      `BGX_IDX_OUT5_LO: bgx_mapped = 1'b1;
      `BGX_IDX_DIR5_LO: bgx_mapped = 1'b1;
      default:          bgx_mapped = 1'b0;
    endcase
  endfunction : bgx_mapped

  // read mux; unmapped reads return zero
  function automatic logic [7:0] bgx_read(
    input logic [7:0]          addr,
    input bgx_pkg::bgx_state_t s,
    input logic [7:0]          pins,
    input logic [2:0]          hi
  );
    logic [5:0] idx;
    idx = addr[7:2];
    case (idx)
      `BGX_IDX_DIR4_HI: bgx_read = s.dir4_hi;
      `BGX_IDX_IN5_LO:  bgx_read = pins;
      `BGX_IDX_IN5_HI:  bgx_read = {5'h00, hi};
      `BGX_IDX_OUT5_LO: bgx_read = s.out5_lo;
      `BGX_IDX_DIR5_LO: bgx_read = s.dir5_lo;
      default:          bgx_read = 8'h00;
    endcase
  endfunction : bgx_read

  // ---------------------------------------------------------------
  // handshakes
  // ---------------------------------------------------------------
  assign aw_take  = s_axi_awvalid && st.awready;
  assign w_take   = s_axi_wvalid && st.wready;
  assign ar_take  = s_axi_arvalid && st.arready;
  assign do_write = st.aw_held && st.w_held && !st.bvalid;
  assign wr_hit   = bgx_mapped(st.aw_addr);
  assign wr_byte  = st.w_data;
  assign rd_hit   = bgx_mapped(s_axi_araddr);
  // pin mirrors: 0 low, 1 high, bits in pin order
  assign rd_byte  = bgx_read(s_axi_araddr, st, x5_sync, hi_sync);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;

    // write address and data are captured independently
    if (aw_take) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (w_take) begin
      next_st.w_held  = 1'b1;
      next_st.w_data  = s_axi_wdata[7:0];
      next_st.w_strb0 = s_axi_wstrb[0];
    end

    if (s_axi_bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end

    if (do_write) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = wr_hit ? `BGX_RESP_OKAY : `BGX_RESP_SLVERR;
      if (st.w_strb0) begin
        case (st.aw_addr[7:2])
          // reserved bits 2..6 are kept as written
          `BGX_IDX_DIR4_HI: next_st.dir4_hi = wr_byte;
          `BGX_IDX_OUT5_LO: next_st.out5_lo = wr_byte;
          `BGX_IDX_DIR5_LO: next_st.dir5_lo = wr_byte;
          // input mirrors take no write
          `BGX_IDX_IN5_LO:  next_st.dir4_hi = st.dir4_hi;
          `BGX_IDX_IN5_HI:  next_st.dir4_hi = st.dir4_hi;
          default:          next_st.dir4_hi = st.dir4_hi;
        endcase
      end
    end

    next_st.awready = !next_st.aw_held && !next_st.bvalid;
    next_st.wready  = !next_st.w_held && !next_st.bvalid;

    // read channel
    if (s_axi_rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (ar_take) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd_byte;
      next_st.rresp  = rd_hit ? `BGX_RESP_OKAY : `BGX_RESP_SLVERR;
    end
    next_st.arready = !next_st.rvalid;
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st         <= '0;
      st.dir4_hi <= `BGX_RST_DIR4_HI;
      st.out5_lo <= `BGX_RST_OUT5_LO;
      st.dir5_lo <= `BGX_RST_DIR5_LO;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // pin drivers: bit n of the output byte drives pin n
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      bgx_pin_cell u_cell (
        .mclk_i    (mclk_i),
        .nrst_i    (nrst_i),
        .value_i   (st.out5_lo[g]),
        .dir_out_i (st.dir5_lo[g]),
        .pin_o     (x5_pin_o[g]),
        .pin_oe_o  (x5_pin_oe_o[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign s_axi_awready  = st.awready;
  assign s_axi_wready   = st.wready;
  assign s_axi_bvalid   = st.bvalid;
  assign s_axi_bresp    = st.bresp;
  assign s_axi_arready  = st.arready;
  assign s_axi_rvalid   = st.rvalid;
  assign s_axi_rdata    = {24'h000000, st.rdata};
  assign s_axi_rresp    = st.rresp;
  assign x4_pin8_dir_o  = st.dir4_hi[`BGX_DIR4_PIN8];
  assign x4_pin9_dir_o  = st.dir4_hi[`BGX_DIR4_PIN9];
  assign x4_pin15_dir_o = st.dir4_hi[`BGX_DIR4_PIN15];

endmodule : bgx_gpio_regs

// *** testbench/bgx_gpio_regs_checker.sv ***
`timescale 1ns/10ps
module bgx_gpio_regs_checker (
  input wire logic        mclk_i,
  input wire logic        nrst_i,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_bvalid,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        x4_pin8_dir_o,
  input wire logic        x4_pin9_dir_o,
  input wire logic        x4_pin15_dir_o,
  input wire logic [7:0]  x5_pin_i,
  input wire logic [7:0]  x5_pin_o,
  input wire logic [7:0]  x5_pin_oe_o,
  input wire logic        lane_switch3_sel_hi_i,
  input wire logic        config_done_pin_i,
  input wire logic        expander_io_enable_pin_i
);
  logic [7:0] aw_q;
  logic [7:0] w_q;
  logic [7:0] ar_q;
  logic       ws_q;
  logic [2:0] hi_w;
  assign hi_w = {expander_io_enable_pin_i, config_done_pin_i,
                 lane_switch3_sel_hi_i};
  always_ff @(posedge mclk_i) begin
    if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) begin
      w_q  <= s_axi_wdata[7:0];
      ws_q <= s_axi_wstrb[0];
    end
    if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_rd(logic [7:0] a); $rose(s_axi_rvalid) && ar_q == a; endsequence
  sequence s_wr(logic [7:0] a); $rose(s_axi_bvalid) && aw_q == a; endsequence
  // pins held long enough to have passed the synchroniser
  sequence s_calm; x5_pin_i == $past(x5_pin_i, 4); endsequence
  sequence s_hcalm; hi_w == $past(hi_w, 4); endsequence
  property p_dir;
    s_rd(8'h5c) |-> {s_axi_rdata[7], s_axi_rdata[1:0]} ==
      {x4_pin15_dir_o, x4_pin9_dir_o, x4_pin8_dir_o};
  endproperty
  property p_in_lo;
    s_rd(8'h60) ##0 s_calm |-> s_axi_rdata[7:0] == x5_pin_i;
  endproperty
  property p_in_hi;
    s_rd(8'h64) ##0 s_hcalm |-> s_axi_rdata[7:0] == {5'h00, hi_w};
  endproperty
  property p_ro;
    $rose(s_axi_bvalid) && aw_q[7:3] == 5'h0c |-> s_axi_bresp == 2'h0
      ##1 $stable(x5_pin_o) && $stable(x5_pin_oe_o);
  endproperty
  property p_drive; s_wr(8'h68) ##0 ws_q |-> ##1 x5_pin_o == w_q; endproperty
  property p_oe; s_wr(8'h70) ##0 ws_q |-> ##1 x5_pin_oe_o == w_q; endproperty
  property p_nostrb;
    s_wr(8'h68) ##0 !ws_q |-> ##1 $stable(x5_pin_o);
  endproperty
  property p_out_rd; s_rd(8'h68) |-> s_axi_rdata[7:0] == x5_pin_o; endproperty
  property p_rst;
    $rose(nrst_i) |-> x5_pin_o == 8'h00 && x5_pin_oe_o == 8'h00;
  endproperty
  property p_bad; s_wr(8'h74) |-> s_axi_bresp == 2'h2; endproperty
  a_dir: assert property (p_dir)
    else $error("direction bits differ from pins");
  a_in_lo: assert property (p_in_lo)
    else $error("low input byte differs from pins");
  a_in_hi: assert property (p_in_hi)
    else $error("high input byte differs from pins");
  a_ro: assert property (p_ro)
    else $error("input byte write had an effect");
  a_drive: assert property (p_drive)
    else $error("output pins differ from written byte");
  a_oe: assert property (p_oe)
    else $error("drive enables differ from written byte");
  a_out_rd: assert property (p_out_rd)
    else $error("output byte read differs from pins");
  a_rst: assert property (p_rst)
    else $error("pins not idle after reset");
  a_bad: assert property (p_bad)
    else $error("unmapped write not refused");
  a_nostrb: assert property (p_nostrb)
    else $error("output pins moved on a write without strobe");
endmodule : bgx_gpio_regs_checker
bind bgx_gpio_regs bgx_gpio_regs_checker i_bgx_gpio_regs_checker (.*);

// *** testbench/bgx_pin_model.sv ***
`timescale 1ns/10ps
module bgx_pin_model (
  input  wire logic [7:0] x5_pin_o,
  input  wire logic [7:0] x5_pin_oe_o,
  input  wire logic [7:0] ext_level_i,
  output logic      [7:0] x5_pin_i
);
  // a driven pin reads the driven level, an undriven one the board level
  assign x5_pin_i = (x5_pin_oe_o & x5_pin_o) | (~x5_pin_oe_o & ext_level_i);
endmodule : bgx_pin_model

// *** testbench/bgx_gpio_regs_tb.sv ***
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  mismatches++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module bgx_gpio_regs_tb;
  logic        mclk_i = 1'b0, nrst_i = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        x4_pin8_dir_o, x4_pin9_dir_o, x4_pin15_dir_o;
  logic [7:0]  x5_pin_i, x5_pin_o, x5_pin_oe_o, rd, ext = 8'h00;
  logic        lane_switch3_sel_hi_i = 1'b0, config_done_pin_i = 1'b0;
  logic        expander_io_enable_pin_i = 1'b0;
  int          mismatches = 0, n_compared = 0, cyc = 0;

  bgx_gpio_regs i_bgx_gpio_regs (.*);
  bgx_pin_model i_bgx_pin_model (.x5_pin_o(x5_pin_o),
    .x5_pin_oe_o(x5_pin_oe_o), .ext_level_i(ext), .x5_pin_i(x5_pin_i));

  always #20 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      test_done();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (s_axi_bvalid !== 1'b1) begin
      @(posedge mclk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    @(posedge mclk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (s_axi_rvalid !== 1'b1) begin
      @(posedge mclk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    rd = s_axi_rdata[7:0];
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rdr

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    rdr(a);
    `CHK("read data", e, rd)
  endtask : rchk

  task automatic t_reset;
    rchk(8'h68, 8'h00);
    `CHK("drive enables", 8'h00, x5_pin_oe_o)
  endtask : t_reset

  task automatic t_dir;
    wr(8'h5c, 8'h83);
    rchk(8'h5c, 8'h83);
    `CHK("dir", 3'h7, {x4_pin15_dir_o, x4_pin9_dir_o, x4_pin8_dir_o})
    wr(8'h5c, 8'h7c);
    rchk(8'h5c, 8'h7c);
    `CHK("dir", 3'h0, {x4_pin15_dir_o, x4_pin9_dir_o, x4_pin8_dir_o})
  endtask : t_dir

  task automatic t_out;
    wr(8'h70, 8'hff);
    for (int i = 0; i < 8; i++) begin
      wr(8'h68, 8'h01 << i);
      repeat (4) @(posedge mclk_i);
      `CHK("pins", 8'h01 << i, x5_pin_o)
      rchk(8'h60, 8'h01 << i);
    end
    ext <= 8'h5a;
    wr(8'h70, 8'h0f);
    repeat (4) @(posedge mclk_i);
    rchk(8'h60, 8'h50);
    wr(8'h70, 8'h00);
    repeat (4) @(posedge mclk_i);
    rchk(8'h60, 8'h5a);
    rchk(8'h68, 8'h80);
  endtask : t_out

  task automatic t_ro;
    for (int i = 0; i < 8; i++) begin
      {expander_io_enable_pin_i, config_done_pin_i,
       lane_switch3_sel_hi_i} <= i[2:0];
      repeat (4) @(posedge mclk_i);
      rchk(8'h64, {5'h00, i[2:0]});
    end
    wr(8'h64, 8'h00);
    `CHK("write resp", 2'h0, rsp)
    rchk(8'h64, 8'h07);
    config_done_pin_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    rchk(8'h64, 8'h05);
    wr(8'h60, 8'hff);
    rchk(8'h60, 8'h5a);
    s_axi_wstrb <= 4'he;
    wr(8'h68, 8'h3c);
    s_axi_wstrb <= 4'hf;
    `CHK("masked write resp", 2'h0, rsp)
    rchk(8'h68, 8'h80);
    wr(8'h74, 8'h11);
    `CHK("unmapped write resp", 2'h2, rsp)
    rdr(8'h74);
    `CHK("unmapped read resp", 2'h2, rsp)
  endtask : t_ro

  // reset in mid-run must bring every register back to its reset value
  task automatic t_rerst;
    nrst_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    nrst_i <= 1'b1;
    rchk(8'h68, 8'h00);
    rchk(8'h70, 8'h00);
    rchk(8'h5c, 8'h00);
    `CHK("drive enables", 8'h00, x5_pin_oe_o)
    `CHK("pins", 8'h00, x5_pin_o)
  endtask : t_rerst

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (4) @(posedge mclk_i);
    nrst_i <= 1'b1;
    t_reset();
    t_dir();
    t_out();
    t_ro();
    t_rerst();
    test_done();
  end
endmodule : bgx_gpio_regs_tb
